// ==== ddcra_host_model.sv ====
`timescale 1ns/10ps
module ddcra_host_model import ddcra_pkg::*; (
    input wire logic clk, // System clock
    input wire logic lsb_mode, // Bit order in use
    input wire logic sdio_wire, // Resolved data line
    output logic port_select_n, // Serial port select
    output logic sclk_in, // Shift clock
    output logic host_sdio // Host side of data line
);
    logic bit_reg;
    logic host_en;
    logic junk_reg = 1'b0;

    // ------------------------------------------------------------
    // Released line
    // ------------------------------------------------------------
    // A released line toggles so that a stale bit can never pass for data
    always @(posedge clk) begin
        junk_reg <= ~junk_reg;
    end
    assign host_sdio = host_en ? bit_reg : junk_reg;

    initial begin
        port_select_n = 1'b1;
        sclk_in = 1'b0;
        host_en = 1'b0;
        bit_reg = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic put_bit(input logic b);
        bit_reg = b;
        host_en = 1'b1;
        tick(2);
        sclk_in = 1'b1;
        tick(2);
        sclk_in = 1'b0;
    endtask

    // Low phase of 3 cycles leaves room for the one-cycle read latency
    task automatic get_bit(output logic b);
        host_en = 1'b0;
        tick(3);
        b = sdio_wire;
        sclk_in = 1'b1;
        tick(2);
        sclk_in = 1'b0;
    endtask

    // ------------------------------------------------------------
    // One-byte frame
    // ------------------------------------------------------------
    task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
        logic [15:0] instr;
        logic b;
        int i;
        instr = {rd, 2'b00, addr};
        rdata = 8'h00;
        port_select_n = 1'b0;
        tick(2);
        for (i = 0; i < 16; i++) begin
            put_bit(lsb_mode ? instr[i] : instr[15 - i]);
        end
        for (i = 0; i < 8; i++) begin
            if (rd) begin
                get_bit(b);
                rdata[lsb_mode ? i : 7 - i] = b;
            end else begin
                put_bit(wdata[lsb_mode ? i : 7 - i]);
            end
        end
        host_en = 1'b0;
        tick(2);
        port_select_n = 1'b1;
        tick(3);
    endtask
endmodule // ddcra_host_model

// ==== ddcra_pkg.sv ====
package ddcra_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
    localparam logic [12:0] ADDR_PART_ID = 13'h0001;
    localparam logic [12:0] ADDR_GRADE = 13'h0002;
    localparam logic [12:0] ADDR_CHAN_IDX = 13'h0005;
    localparam logic [12:0] ADDR_PWR_MODE = 13'h0008;
    localparam logic [12:0] ADDR_CLK_GLOBAL = 13'h0009;
    localparam logic [12:0] ADDR_XFER = 13'h00FF;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_CFG_RST = 8'h18;
    localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
    localparam int CFG_LSB_HI = 6;
    localparam int CFG_LSB_LO = 1;
    localparam int CFG_SRST_HI = 5;
    localparam int CFG_SRST_LO = 2;
    localparam logic [1:0] CHAN_IDX_RST = 2'h3;
    localparam logic [1:0] CHAN_BOTH = 2'h3;
    localparam int XFER_BIT = 0;
    localparam int GRADE_SPEED_LSB = 4;
    localparam logic [7:0] PWR_MODE_RST = 8'h00;
    localparam logic [7:0] PWR_MODE_MASK = 8'h23;
    localparam int PWR_EXT_PIN_BIT = 5;
    localparam logic [7:0] CLK_GLOBAL_RST = 8'h01;
    localparam logic [7:0] CLK_GLOBAL_MASK = 8'h01;
    localparam int CLK_DCS_BIT = 0;

    // ----------------------------------------------------------------
    // Serial framing
    // ----------------------------------------------------------------
    localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
    localparam int INSTR_RW_BIT = 15;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam int NUM_CHAN = 2;

    typedef enum logic [1:0] {
        DDCRA_IDLE = 2'b00,
        DDCRA_INSTR = 2'b01,
        DDCRA_DATA = 2'b11
    } ddcra_frame_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] data;
    } ddcra_wr_t;

    typedef struct packed {
        logic ext_pin_standby;
        logic [1:0] pdn_mode;
    } ddcra_chan_ctrl_t;

endpackage

// ==== ddcra_regbank.sv ====
`timescale 1ns/10ps
module ddcra_regbank import ddcra_pkg::*; #(
    parameter logic [7:0] PART_IDENTITY_CODE = 8'hA5, // Arbitrary value
    parameter logic [1:0] SPEED_CODE = 2'h1 // Arbitrary value
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Asynchronous reset
    input wire logic ce, // Clock enable
    input wire logic port_select_n, // Serial port select
    input wire logic sclk_in, // Serial shift clock
    input wire logic sdio_in, // Serial data in
    output logic sdio_out, // Serial data out
    output logic sdio_oe_n, // Low while driving data
    output ddcra_chan_ctrl_t [NUM_CHAN-1:0] chan_ctrl, // Live local controls
    output logic duty_stab_en, // Live global control
    output logic lsb_first // Current bit order
);

    // ----------------------------------------------------------------
    // Serial framing
    // ----------------------------------------------------------------
    ddcra_frame_t state_reg;
    logic sclk_q_reg;
    logic [3:0] bit_cnt_reg;
    logic [2:0] bit_idx_reg;
    logic [15:0] instr_sr_reg;
    logic [7:0] byte_sr_reg;
    logic [7:0] rd_byte_reg;
    logic [12:0] addr_reg;
    logic rd_frame_reg;
    logic lsb_first_reg;
    logic [1:0] chan_sel_reg;
    logic rise;
    logic fall;
    logic [15:0] instr_next;
    logic [7:0] byte_next;
    logic [2:0] out_sel;
    logic [7:0] rdata;
    ddcra_wr_t wr;
    logic wr_go;
    logic srst;
    logic xfer;
    logic [7:0] ch_shadow [NUM_CHAN];
    logic [7:0] ch_active [NUM_CHAN];
    logic [7:0] glb_shadow;
    logic [7:0] glb_active;

    assign rise = ce && !port_select_n && sclk_in && !sclk_q_reg;
    assign fall = ce && !port_select_n && !sclk_in && sclk_q_reg;
    // Shifting toward the LSB end in LSB-first mode lands bits in place
    assign instr_next = lsb_first_reg ? {sdio_in, instr_sr_reg[15:1]}
                                      : {instr_sr_reg[14:0], sdio_in};
    assign byte_next = lsb_first_reg ? {sdio_in, byte_sr_reg[7:1]}
                                     : {byte_sr_reg[6:0], sdio_in};
    assign out_sel = lsb_first_reg ? bit_idx_reg : BYTE_LAST_BIT - bit_idx_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q_reg <= 1'b0;
        end else if (ce) begin
            sclk_q_reg <= sclk_in;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= DDCRA_IDLE;
            bit_cnt_reg <= '0;
            bit_idx_reg <= '0;
            instr_sr_reg <= '0;
            byte_sr_reg <= '0;
            addr_reg <= '0;
            rd_frame_reg <= 1'b0;
        end else if (ce) begin
            if (port_select_n) begin
                state_reg <= DDCRA_IDLE;
                bit_cnt_reg <= '0;
                bit_idx_reg <= '0;
                rd_frame_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    DDCRA_IDLE: begin
                        state_reg <= DDCRA_INSTR;
                    end
                    DDCRA_INSTR: begin
                        if (rise) begin
                            instr_sr_reg <= instr_next;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == INSTR_LAST_BIT) begin
                                state_reg <= DDCRA_DATA;
                                rd_frame_reg <= instr_next[INSTR_RW_BIT];
                                addr_reg <= instr_next[ADDR_W-1:0];
                            end
                        end
                    end
                    DDCRA_DATA: begin
                        if (rise) begin
                            byte_sr_reg <= byte_next;
                            bit_idx_reg <= bit_idx_reg + 3'h1;
                            // Streaming: address walks down MSB first, up LSB first
                            if (bit_idx_reg == BYTE_LAST_BIT) begin
                                addr_reg <= lsb_first_reg ? addr_reg + 13'h0001
                                                          : addr_reg - 13'h0001;
                            end
                        end
                    end
                    default: begin
                        state_reg <= DDCRA_IDLE;
                    end
                endcase
            end
        end
    end

    assign wr_go = rise && state_reg == DDCRA_DATA && !rd_frame_reg
                   && bit_idx_reg == BYTE_LAST_BIT;
    assign wr.addr = addr_reg;
    assign wr.data = byte_next;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        rdata = 8'h00;
        unique case (addr_reg)
            ADDR_PORT_CFG: begin
                rdata = PORT_CFG_FIXED;
                rdata[CFG_LSB_HI] = lsb_first_reg;
                rdata[CFG_LSB_LO] = lsb_first_reg;
            end
            ADDR_PART_ID: begin
                rdata = PART_IDENTITY_CODE;
            end
            ADDR_GRADE: begin
                rdata[GRADE_SPEED_LSB +: 2] = SPEED_CODE;
            end
            ADDR_CHAN_IDX: begin
                rdata[1:0] = chan_sel_reg;
            end
            ADDR_PWR_MODE: begin
                // Second copy only when channel B alone is chosen
                rdata = (chan_sel_reg == 2'h2) ? ch_shadow[1] : ch_shadow[0];
            end
            ADDR_CLK_GLOBAL: begin
                rdata = glb_shadow;
            end
            default: begin
                rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_byte_reg <= '0;
            sdio_out <= 1'b0;
        end else if (fall && state_reg == DDCRA_DATA && rd_frame_reg) begin
            if (bit_idx_reg == 3'h0) begin
                rd_byte_reg <= rdata;
                sdio_out <= rdata[out_sel];
            end else begin
                sdio_out <= rd_byte_reg[out_sel];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdio_oe_n <= 1'b1;
        end else if (ce) begin
            sdio_oe_n <= !(state_reg == DDCRA_DATA && rd_frame_reg && !port_select_n);
        end
    end

    // ----------------------------------------------------------------
    // Global control registers
    // ----------------------------------------------------------------
    // Port configuration is ignored unless every channel bit is set
    assign srst = wr_go && wr.addr == ADDR_PORT_CFG && chan_sel_reg == CHAN_BOTH
                  && (wr.data[CFG_SRST_HI] || wr.data[CFG_SRST_LO]);
    assign xfer = wr_go && wr.addr == ADDR_XFER && wr.data[XFER_BIT];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lsb_first_reg <= PORT_CFG_RST[CFG_LSB_HI];
        end else if (wr_go && wr.addr == ADDR_PORT_CFG && chan_sel_reg == CHAN_BOTH) begin
            lsb_first_reg <= wr.data[CFG_LSB_HI] || wr.data[CFG_LSB_LO];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_sel_reg <= CHAN_IDX_RST;
        end else if (ce) begin
            if (srst) begin
                chan_sel_reg <= CHAN_IDX_RST;
            end else if (wr_go && wr.addr == ADDR_CHAN_IDX) begin
                chan_sel_reg <= wr.data[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Function registers
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        ddcra_shadow_reg #(
            .RST_VAL(PWR_MODE_RST),
            .MASK(PWR_MODE_MASK)
        ) u_pwr (
            .clk(clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .wr_en(wr_go && wr.addr == ADDR_PWR_MODE && chan_sel_reg[i]),
            .wr_data(wr.data),
            .xfer(xfer),
            .srst(srst),
            .shadow_q(ch_shadow[i]),
            .active_q(ch_active[i])
        );
        assign chan_ctrl[i].pdn_mode = ch_active[i][1:0];
        assign chan_ctrl[i].ext_pin_standby = ch_active[i][PWR_EXT_PIN_BIT];
    end

    ddcra_shadow_reg #(
        .RST_VAL(CLK_GLOBAL_RST),
        .MASK(CLK_GLOBAL_MASK)
    ) u_clk_global (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr_en(wr_go && wr.addr == ADDR_CLK_GLOBAL),
        .wr_data(wr.data),
        .xfer(xfer),
        .srst(srst),
        .shadow_q(glb_shadow),
        .active_q(glb_active)
    );

    assign duty_stab_en = glb_active[CLK_DCS_BIT];
    assign lsb_first = lsb_first_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_local_one_copy: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && wr.addr == ADDR_PWR_MODE && chan_sel_reg == 2'h1 && !srst)
        |=> (ch_shadow[0] == ($past(wr.data) & PWR_MODE_MASK)) && $stable(ch_shadow[1]))
        else $error("local write did not go to channel A copy only");

    chk_local_both_copies: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && wr.addr == ADDR_PWR_MODE && chan_sel_reg == CHAN_BOTH)
        |=> (ch_shadow[0] == ch_shadow[1])
            && (ch_shadow[1] == ($past(wr.data) & PWR_MODE_MASK)))
        else $error("broadcast local write missed a channel copy");

    chk_read_first_chan: assert property (@(posedge clk) disable iff (sys_rst)
        (addr_reg == ADDR_PWR_MODE && chan_sel_reg == CHAN_BOTH) |-> (rdata == ch_shadow[0]))
        else $error("local read with both channels did not return channel A");

    chk_global_ignores_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && wr.addr == ADDR_CLK_GLOBAL)
        |=> (glb_shadow == ($past(wr.data) & CLK_GLOBAL_MASK)))
        else $error("global write was blocked by channel select");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (addr_reg > ADDR_CLK_GLOBAL) |-> (rdata == 8'h00))
        else $error("unmapped address read nonzero");

    chk_order_switch: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && wr.addr == ADDR_PORT_CFG && chan_sel_reg == CHAN_BOTH
         && wr.data[CFG_LSB_HI] && wr.data[CFG_LSB_LO]) |=> lsb_first ##1 lsb_first)
        else $error("bit order did not switch to LSB first");

    chk_cfg_guard: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_go && wr.addr == ADDR_PORT_CFG && chan_sel_reg != CHAN_BOTH)
        |=> $stable(lsb_first_reg) && $stable(chan_sel_reg))
        else $error("port configuration changed without all channel bits");

    chk_xfer_self_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (addr_reg == ADDR_XFER) |-> (rdata == 8'h00))
        else $error("transfer bit did not read back cleared");

endmodule // ddcra_regbank

// ==== ddcra_shadow_reg.sv ====
`timescale 1ns/10ps
module ddcra_shadow_reg import ddcra_pkg::*; #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Asynchronous reset
    input wire logic ce, // Clock enable
    input wire logic wr_en, // Write into shadow
    input wire logic [7:0] wr_data, // Write data
    input wire logic xfer, // Copy shadow to active
    input wire logic srst, // Soft reset to defaults
    output logic [7:0] shadow_q, // Shadow value
    output logic [7:0] active_q // Live value
);

    // A reset value outside the mask could never be restored by a host write
    if ((RST_VAL & ~MASK) != 8'h00) begin : g_bad_rst
        $error("reset value sets bits outside the write mask");
    end

    // ----------------------------------------------------------------
    // Shadow and active storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shadow_q <= RST_VAL;
        end else if (ce) begin
            if (srst) begin
                shadow_q <= RST_VAL;
            end else if (wr_en) begin
                shadow_q <= wr_data & MASK;
            end
        end
    end

    // Live copy moves only on transfer or soft reset, so all shadows switch in one cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_q <= RST_VAL;
        end else if (ce) begin
            if (srst) begin
                active_q <= RST_VAL;
            end else if (xfer) begin
                active_q <= shadow_q;
            end
        end
    end

    chk_xfer_copies: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && xfer && !srst) |=> (active_q == $past(shadow_q)))
        else $error("active value not loaded from shadow on transfer");

    chk_active_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (!(ce && (xfer || srst))) |=> $stable(active_q))
        else $error("active value changed without transfer");

endmodule // ddcra_shadow_reg

// ==== tb_dual_channel_register_addressing.sv ====
`timescale 1ns/10ps
module tb_dual_channel_register_addressing import ddcra_pkg::*;;
    localparam logic [7:0] TB_PART_ID = 8'h3C; // Arbitrary value
    localparam logic [1:0] TB_SPEED = 2'h2; // Arbitrary value
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic lsb_mode = 1'b0;
    logic port_select_n, sclk_in, host_sdio, sdio_wire, sdio_out, sdio_oe_n;
    logic duty_stab_en, lsb_first;
    ddcra_chan_ctrl_t [NUM_CHAN-1:0] chan_ctrl;
    int err_count = 0;
    int n_checks = 0;
    int seed = 87213;
    int k;
    logic [7:0] exp_a, exp_b, exp_g, live_a, live_b, live_g, rd_val, v;

    always #5 clk = ~clk;
    assign sdio_wire = !sdio_oe_n ? sdio_out : host_sdio;

    ddcra_regbank #(.PART_IDENTITY_CODE(TB_PART_ID), .SPEED_CODE(TB_SPEED)) uut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .port_select_n(port_select_n),
        .sclk_in(sclk_in), .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .chan_ctrl(chan_ctrl), .duty_stab_en(duty_stab_en), .lsb_first(lsb_first)
    );
    ddcra_host_model host (
        .clk(clk), .lsb_mode(lsb_mode), .sdio_wire(sdio_wire),
        .port_select_n(port_select_n), .sclk_in(sclk_in), .host_sdio(host_sdio)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host.frame(1'b0, a, d, rd_val);
    endtask

    task automatic rd(input string name, input logic [12:0] a, input logic [7:0] exp);
        host.frame(1'b1, a, 8'h00, rd_val);
        check(name, rd_val, exp);
    endtask

    function automatic logic [7:0] cfg_exp(input logic lsb);
        return PORT_CFG_FIXED | (lsb ? 8'h42 : 8'h00);
    endfunction

    function automatic logic [7:0] local_exp(input logic [1:0] sel);
        return (sel == 2'h2) ? exp_b : exp_a;
    endfunction

    function automatic logic [7:0] ctrl_of(input logic [7:0] r);
        return {5'h00, r[5], r[1:0]};
    endfunction

    task automatic live_chk();
        check("chan_a", {5'h00, chan_ctrl[0]}, ctrl_of(live_a));
        check("chan_b", {5'h00, chan_ctrl[1]}, ctrl_of(live_b));
        check("duty_stab", {7'h00, duty_stab_en}, live_g & CLK_GLOBAL_MASK);
    endtask

    task automatic xfer();
        wr(ADDR_XFER, 8'h01);
        live_a = exp_a;
        live_b = exp_b;
        live_g = exp_g;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // About 70 frames of some 1.1 us each; five times that is ample
    initial begin
        #400000;
        err_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        host.tick(2);
        exp_a = PWR_MODE_RST;
        exp_b = PWR_MODE_RST;
        exp_g = CLK_GLOBAL_RST;
        live_a = exp_a;
        live_b = exp_b;
        live_g = exp_g;
        rd("port_cfg", ADDR_PORT_CFG, cfg_exp(1'b0));
        rd("part_id", ADDR_PART_ID, TB_PART_ID);
        wr(ADDR_PART_ID, ~TB_PART_ID);
        rd("part_id_ro", ADDR_PART_ID, TB_PART_ID);
        rd("grade", ADDR_GRADE, {2'b00, TB_SPEED, 4'h0});
        rd("chan_idx", ADDR_CHAN_IDX, {6'h00, CHAN_IDX_RST});
        rd("unmapped", 13'h0003, 8'h00);
        check("lsb_first", {7'h00, lsb_first}, 8'h00);
        live_chk();
        $display("test reset done");

        for (k = 0; k < 3; k++) begin
            v = 8'($random(seed));
            exp_a = v & PWR_MODE_MASK;
            v = 8'($random(seed));
            exp_b = v & PWR_MODE_MASK;
            wr(ADDR_CHAN_IDX, 8'h01);
            wr(ADDR_PWR_MODE, exp_a);
            wr(ADDR_CHAN_IDX, 8'h02);
            wr(ADDR_PWR_MODE, exp_b);
            live_chk();
            rd("local_b", ADDR_PWR_MODE, local_exp(2'h2));
            wr(ADDR_CHAN_IDX, 8'h01);
            rd("local_a", ADDR_PWR_MODE, local_exp(2'h1));
            wr(ADDR_CHAN_IDX, 8'h03);
            rd("both_read", ADDR_PWR_MODE, local_exp(2'h3));
            xfer();
            live_chk();
            rd("xfer_clr", ADDR_XFER, 8'h00);
        end
        $display("test channel copies done");

        exp_a = 8'h21;
        exp_b = 8'h21;
        wr(ADDR_PWR_MODE, exp_a);
        wr(ADDR_CHAN_IDX, 8'h02);
        rd("both_wr_b", ADDR_PWR_MODE, exp_b);
        wr(ADDR_CHAN_IDX, 8'h01);
        rd("both_wr_a", ADDR_PWR_MODE, exp_a);
        exp_g = 8'h00;
        wr(ADDR_CLK_GLOBAL, exp_g);
        wr(ADDR_CHAN_IDX, 8'h02);
        rd("global_rd", ADDR_CLK_GLOBAL, exp_g);
        // Clock enable low: a whole write frame must pass unseen
        ce = 1'b0;
        wr(ADDR_CLK_GLOBAL, 8'h01);
        ce = 1'b1;
        host.tick(1);
        rd("ce_frozen", ADDR_CLK_GLOBAL, exp_g);
        live_chk();
        xfer();
        live_chk();
        $display("test both and global done");

        wr(ADDR_PORT_CFG, cfg_exp(1'b1));
        check("cfg_refused", {7'h00, lsb_first}, 8'h00);
        rd("port_cfg_kept", ADDR_PORT_CFG, cfg_exp(1'b0));
        wr(ADDR_CHAN_IDX, 8'h03);
        wr(ADDR_PORT_CFG, cfg_exp(1'b1));
        lsb_mode = 1'b1;
        check("lsb_set", {7'h00, lsb_first}, 8'h01);
        rd("port_cfg_lsb", ADDR_PORT_CFG, cfg_exp(1'b1));
        wr(ADDR_CHAN_IDX, 8'h01);
        exp_a = 8'h02;
        wr(ADDR_PWR_MODE, exp_a);
        rd("lsb_local", ADDR_PWR_MODE, exp_a);
        wr(ADDR_CHAN_IDX, 8'h03);
        wr(ADDR_PORT_CFG, cfg_exp(1'b1) | 8'h24);
        exp_a = PWR_MODE_RST;
        exp_b = PWR_MODE_RST;
        exp_g = CLK_GLOBAL_RST;
        live_a = exp_a;
        live_b = exp_b;
        live_g = exp_g;
        live_chk();
        check("lsb_kept", {7'h00, lsb_first}, 8'h01);
        wr(ADDR_CHAN_IDX, 8'h01);
        rd("srst_idx", ADDR_CHAN_IDX, 8'h01);
        wr(ADDR_CHAN_IDX, 8'h03);
        rd("srst_cfg", ADDR_PORT_CFG, cfg_exp(1'b1));
        wr(ADDR_PORT_CFG, cfg_exp(1'b0));
        lsb_mode = 1'b0;
        check("msb_back", {7'h00, lsb_first}, 8'h00);
        rd("port_cfg_msb", ADDR_PORT_CFG, cfg_exp(1'b0));
        $display("test port config done");
        conclude();
    end
endmodule // tb_dual_channel_register_addressing
